// [sram_port_pkg.sv]
package sram_port_pkg;

  // ---------------------------------------------------------------------
  // Data bus and byte lanes
  // ---------------------------------------------------------------------
  localparam int DQ_W = 36;
  localparam int LANE_W = 9;
  localparam int LANES = 4;
  localparam int NIBBLE_W = 4;

  // Width configurations, held in the control register.
  localparam logic [1:0] WIDTH_X8 = 2'h0;
  localparam logic [1:0] WIDTH_X18 = 2'h1;
  localparam logic [1:0] WIDTH_X36 = 2'h2;

  // ---------------------------------------------------------------------
  // Register map, byte addresses on the AHB-Lite bus
  // ---------------------------------------------------------------------
  localparam int REG_ADDR_W = 8;
  localparam logic [7:0] REG_CTRL = 8'h00;
  localparam logic [7:0] REG_STATUS = 8'h04;
  localparam logic [7:0] REG_LAST_ADDR = 8'h08;
  localparam logic [7:0] REG_XFER_COUNT = 8'h0C;

  localparam int CTRL_WIDTH_LSB = 0;
  localparam int CTRL_EN_BIT = 2;
  localparam logic [1:0] CTRL_WIDTH_RESET = 2'h2;
  localparam logic CTRL_EN_RESET = 1'b1;

  localparam int STATUS_BUSY_BIT = 0;
  localparam int STATUS_DLL_BYPASS_BIT = 1;
  localparam int STATUS_K_OUT_BIT = 2;
  localparam int STATUS_LAST_READ_BIT = 3;

  localparam int XFER_COUNT_W = 16;

  // ---------------------------------------------------------------------
  // Timing
  // ---------------------------------------------------------------------
  localparam int CLK_PERIOD_NS = 25;
  localparam int LINK_PERIOD_NS = 200;
  // Idle levels of the four link clock pins, true clocks low.
  localparam logic [3:0] CLK_PINS_IDLE = 4'h5;
  // Both output clocks high for a whole link period means they are tied.
  localparam logic [3:0] C_STATIC_CYCLES =
    4'(LINK_PERIOD_NS / CLK_PERIOD_NS);

  // ---------------------------------------------------------------------
  // Burst sequencer states
  // ---------------------------------------------------------------------
  typedef enum logic [3:0] {
    ST_IDLE = 4'b0001,
    ST_WR = 4'b0010,
    ST_RD = 4'b0100,
    ST_TAIL = 4'b1000
  } burst_state_t;

endpackage

// [pin_sync.sv]
`timescale 1ns/1ps
`default_nettype none

module pin_sync #(
  parameter int W = 1,
  parameter logic [W-1:0] INIT = '0
) (
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);

  logic [W-1:0] meta;

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      meta <= INIT;
      q <= INIT;
    end else begin
      meta <= d;
      q <= meta;
    end
  end

endmodule // pin_sync

`default_nettype wire

// [burst_sram_port.sv]
// Functional notes
// RULE_01: Lane stored only when its enable is low.
// RULE_02: Enables checked separately on each write beat.
// RULE_03: Lane three enable gates lines 27 to 35.
// RULE_04: Lane zero enable gates lines 0 to 8.
// RULE_05: Read words one and three on inverted clock.
// RULE_06: Read words two and four on true clock.
// RULE_07: Output clocks tied high selects input clocks.
// RULE_08: Low disable input bypasses the delay loop.
// RULE_09: Address and control taken on true rise.
// RULE_10: Write data taken on both input clock rises.
// RULE_11: Controller pulls load low with address, direction.
// RULE_12: Every burst moves exactly four words; a write load on the last read launch clears dq_oe, so word four is not driven.
// RULE_13: Direction high reads, low writes.
// RULE_14: Two low address bits pick start word.
// RULE_15: Address ignored when no load is taken.
// RULE_16: Bus width follows 8, 18 or 36 lines.
// RULE_17: Low address bits count up modulo four.
// RULE_18: Narrow bus controller keeps start bits zero.
// RULE_19: Loads spaced at least two clock periods.
//
// Decided for this implementation: the address map and the AHB-Lite interface to the registers.
`timescale 1ns/1ps
`default_nettype none

module burst_sram_port
  import sram_port_pkg::*;
#(
  parameter int UPPER_W = 4
) (
  input wire logic sys_clk,
  input wire logic rst_n,
  // AHB-Lite register slave.
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  // Memory link pins.
  input wire logic in_clk,
  input wire logic in_clk_n,
  input wire logic out_clk,
  input wire logic out_clk_n,
  input wire logic load_n,
  input wire logic read_not_write,
  input wire logic dll_disable_n,
  input wire logic word_addr_bit0,
  input wire logic word_addr_bit1,
  input wire logic [UPPER_W-1:0] upper_addr,
  input wire logic [LANES-1:0] lane_write_enable_n,
  input wire logic [DQ_W-1:0] dq_in,
  output logic [DQ_W-1:0] dq_out,
  output logic [DQ_W-1:0] dq_oe,
  output logic dll_bypassed
);

  localparam int ADDR_W = UPPER_W + 2;
  localparam int DEPTH = 1 << ADDR_W;
  localparam int SYNC_W = 9 + UPPER_W + LANES + DQ_W;
  // Sync stages reset to each pin's idle level, so no false edge follows.
  localparam logic [SYNC_W-1:0] SYNC_INIT = {CLK_PINS_IDLE, 3'h5, 2'h0,
    {UPPER_W{1'b0}}, {LANES{1'b1}}, {DQ_W{1'b0}}};

  typedef struct packed {
    burst_state_t state;
    logic [1:0] beat;
    logic [1:0] start;
    logic [UPPER_W-1:0] upper;
    logic [3:0] prev_clk;
    logic [3:0] static_cnt;
    logic [DQ_W-1:0] dq_out;
    logic [DQ_W-1:0] dq_oe;
    logic dll_bypassed;
    logic [1:0] ctrl_width;
    logic ctrl_en;
    logic last_read;
    logic [XFER_COUNT_W-1:0] xfer_count;
    logic wr_pend;
    logic [REG_ADDR_W-1:0] wr_addr;
    logic [31:0] hrdata;
    logic hreadyout;
    logic [DEPTH-1:0][DQ_W-1:0] mem;
  } port_state_t;

  port_state_t s;
  port_state_t next;

  // -----------------------------------------------------------------------
  // Pin synchronisers
  // -----------------------------------------------------------------------
  logic [SYNC_W-1:0] sync_q;
  logic k_s, kn_s, c_s, cn_s, load_n_s, rd_s, dll_n_s, a1_s, a0_s;
  logic [UPPER_W-1:0] upper_s;
  logic [LANES-1:0] lane_n_s;
  logic [DQ_W-1:0] dq_s;

  pin_sync #(.W(SYNC_W), .INIT(SYNC_INIT)) link_sync (
    .sys_clk(sys_clk),
    .rst_n(rst_n),
    .d({in_clk, in_clk_n, out_clk, out_clk_n, load_n, read_not_write,
        dll_disable_n, word_addr_bit1, word_addr_bit0, upper_addr,
        lane_write_enable_n, dq_in}),
    .q(sync_q)
  );

  assign {k_s, kn_s, c_s, cn_s, load_n_s, rd_s, dll_n_s, a1_s, a0_s,
          upper_s, lane_n_s, dq_s} = sync_q;

  // -----------------------------------------------------------------------
  // Lane decoding
  // -----------------------------------------------------------------------
  // Active-high mask of the lines that a beat may write.
  function automatic logic [DQ_W-1:0] lane_mask(input logic [1:0] w,
                                                input logic [3:0] en_n);
    logic [DQ_W-1:0] m;
    m = '0;
    unique case (w)
      WIDTH_X8: m = {28'h0, {NIBBLE_W{~en_n[1]}}, {NIBBLE_W{~en_n[0]}}};
      WIDTH_X18: m = {18'h0, {LANE_W{~en_n[1]}}, {LANE_W{~en_n[0]}}};
      default: m = {{LANE_W{~en_n[3]}}, {LANE_W{~en_n[2]}},
                    {LANE_W{~en_n[1]}}, {LANE_W{~en_n[0]}}}; // RULE_03 RULE_04
    endcase
    return m;
  endfunction

  // Lines in use for a width; the rest never drive.
  function automatic logic [DQ_W-1:0] width_mask(input logic [1:0] w);
    return lane_mask(w, 4'h0);
  endfunction

  function automatic logic [31:0] reg_read(input port_state_t r,
                                          input logic [REG_ADDR_W-1:0] a,
                                          input logic use_k);
    logic [31:0] v;
    v = 32'h0;
    unique case (a)
      REG_CTRL: begin
        v[CTRL_WIDTH_LSB +: 2] = r.ctrl_width;
        v[CTRL_EN_BIT] = r.ctrl_en;
      end
      REG_STATUS: begin
        v[STATUS_BUSY_BIT] = (r.state != ST_IDLE);
        v[STATUS_DLL_BYPASS_BIT] = r.dll_bypassed;
        v[STATUS_K_OUT_BIT] = use_k;
        v[STATUS_LAST_READ_BIT] = r.last_read;
      end
      REG_LAST_ADDR: v = 32'({r.upper, r.start});
      REG_XFER_COUNT: v = 32'(r.xfer_count);
      default: v = 32'h0;
    endcase
    return v;
  endfunction

  // -----------------------------------------------------------------------
  // Link clock edges and read launch selection
  // -----------------------------------------------------------------------
  logic k_rise, kn_rise, c_rise, cn_rise, use_k;
  logic launch_even, launch_odd;

  assign k_rise = k_s & ~s.prev_clk[3];
  assign kn_rise = kn_s & ~s.prev_clk[2];
  assign c_rise = c_s & ~s.prev_clk[1];
  assign cn_rise = cn_s & ~s.prev_clk[0];
  assign use_k = (s.static_cnt == C_STATIC_CYCLES); // RULE_07
  assign launch_even = use_k ? kn_rise : cn_rise; // RULE_05
  assign launch_odd = use_k ? k_rise : c_rise; // RULE_06

  // -----------------------------------------------------------------------
  // Next state
  // -----------------------------------------------------------------------
  logic mem_we, load_ok;
  logic [1:0] wr_lo;
  logic [ADDR_W-1:0] wr_idx;
  logic [DQ_W-1:0] wr_mask;

  always_comb begin
    next = s;
    mem_we = 1'b0;
    wr_lo = s.start + s.beat; // RULE_17
    wr_idx = {s.upper, wr_lo};
    wr_mask = lane_mask(s.ctrl_width, lane_n_s); // RULE_02
    next.prev_clk = {k_s, kn_s, c_s, cn_s};
    next.dll_bypassed = ~dll_n_s; // RULE_08
    if (c_s && cn_s) begin
      if (!use_k) begin
        next.static_cnt = s.static_cnt + 4'h1;
      end
    end else begin
      next.static_cnt = 4'h0;
    end
    unique case (s.state)
      ST_IDLE: begin
      end
      ST_WR: begin
        if (s.beat[0] ? kn_rise : k_rise) begin // RULE_10
          mem_we = 1'b1;
          next.beat = s.beat + 2'h1;
          if (s.beat == 2'h3) begin // RULE_12
            next.state = ST_IDLE;
          end
        end
      end
      ST_RD: begin
        if (s.beat[0] ? launch_odd : launch_even) begin // RULE_05 RULE_06
          next.dq_out = s.mem[wr_idx] & width_mask(s.ctrl_width);
          next.dq_oe = width_mask(s.ctrl_width); // RULE_16
          next.beat = s.beat + 2'h1;
          if (s.beat == 2'h3) begin // RULE_12
            next.state = ST_TAIL;
          end
        end
      end
      ST_TAIL: begin
        if (launch_even) begin
          next.dq_oe = '0;
          next.state = ST_IDLE;
        end
      end
    endcase
    // A load may meet the last read launch on the same true-clock rise.
    load_ok = (s.state == ST_IDLE) || (s.state == ST_TAIL) ||
              (next.state == ST_TAIL);
    if (k_rise && !load_n_s && s.ctrl_en && load_ok) begin // RULE_09 RULE_15
      next.upper = upper_s;
      next.start = {a1_s, a0_s}; // RULE_14
      next.last_read = rd_s;
      next.xfer_count = s.xfer_count + 16'h1;
      next.beat = 2'h0;
      if (rd_s) begin // RULE_13
        next.state = ST_RD;
      end else begin
        next.state = ST_WR;
        next.beat = 2'h1;
        next.dq_oe = '0;
        mem_we = 1'b1;
        wr_lo = {a1_s, a0_s};
        wr_idx = {upper_s, a1_s, a0_s};
      end
    end
    if (mem_we) begin // RULE_01
      next.mem[wr_idx] = (s.mem[wr_idx] & ~wr_mask) | (dq_s & wr_mask);
    end
    // AHB-Lite slave: zero wait states, always OKAY.
    next.hreadyout = 1'b1;
    next.wr_pend = 1'b0;
    if (s.wr_pend) begin
      if (s.wr_addr == REG_CTRL) begin
        next.ctrl_width = hwdata[CTRL_WIDTH_LSB +: 2];
        next.ctrl_en = hwdata[CTRL_EN_BIT];
      end
    end
    if (hsel && hready && htrans[1]) begin
      next.wr_pend = hwrite;
      next.wr_addr = haddr[REG_ADDR_W-1:0];
      if (!hwrite) begin
        next.hrdata = reg_read(s, haddr[REG_ADDR_W-1:0], use_k);
      end
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      s <= '{state: ST_IDLE, ctrl_width: CTRL_WIDTH_RESET,
             ctrl_en: CTRL_EN_RESET, hreadyout: 1'b1,
             prev_clk: CLK_PINS_IDLE, default: '0};
    end else begin
      s <= next;
    end
  end

  assign hreadyout = s.hreadyout;
  assign hresp = 1'b0;
  assign hrdata = s.hrdata;
  assign dq_out = s.dq_out;
  assign dq_oe = s.dq_oe;
  assign dll_bypassed = s.dll_bypassed;

  // -----------------------------------------------------------------------
  // Checks
  // -----------------------------------------------------------------------
  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (!rst_n);

  sequence load_read_s;
    k_rise && !load_n_s && rd_s && s.ctrl_en && load_ok;
  endsequence

  sequence first_launch_s;
    s.state == ST_RD && s.beat == 2'h0 ##1 s.beat == 2'h1;
  endsequence

  lane_zero_gate_a: assert property (mem_we && lane_n_s[0] &&  // RULE_04
    s.ctrl_width == WIDTH_X36 |=> s.mem[$past(wr_idx)][8:0] ==
    $past(s.mem[wr_idx][8:0]))
    else $error("lane zero written while disabled");
  lane_three_gate_a: assert property (mem_we && lane_n_s[3] &&  // RULE_03
    s.ctrl_width == WIDTH_X36 |=> s.mem[$past(wr_idx)][35:27] ==
    $past(s.mem[wr_idx][35:27]))
    else $error("lane three written while disabled");
  lane_write_data_a: assert property (mem_we && !lane_n_s[1] &&  // RULE_01
    s.ctrl_width == WIDTH_X36 |=> s.mem[$past(wr_idx)][17:9] ==
    $past(dq_s[17:9]))
    else $error("enabled lane not stored");
  write_edge_a: assert property (mem_we |-> k_rise || kn_rise) // RULE_10
    else $error("write beat without input clock rise");
  burst_wrap_a: assert property (s.state == ST_WR && mem_we |->  // RULE_17
    wr_lo == 2'(s.start + s.beat))
    else $error("burst address did not wrap upward");
  burst_four_a: assert property (s.state == ST_WR &&  // RULE_12
    next.state == ST_IDLE |-> s.beat == 2'h3 && mem_we)
    else $error("write burst not four beats");
  read_dir_a: assert property (load_read_s |=> s.state == ST_RD) // RULE_13
    else $error("read direction not honoured");
  addr_hold_a: assert property ($changed(s.start) || $changed(s.upper) |->
    $past(k_rise) && !$past(load_n_s)) // RULE_09
    else $error("address taken without load");
  first_word_a: assert property (first_launch_s |->  // RULE_05
    $past(launch_even))
    else $error("first read word not on even launch");
  kclk_mode_a: assert property (use_k && s.state == ST_RD &&  // RULE_07
    $changed(s.beat) |-> $past(k_rise || kn_rise))
    else $error("tied output clocks not replaced by input clocks");
  width_oe_a: assert property ((dq_oe & ~width_mask(s.ctrl_width)) == '0
    || $changed(s.ctrl_width)) // RULE_16
    else $error("unused data line driven");
  dll_follow_a: assert property (##1 dll_bypassed == !$past(dll_n_s)) // RULE_08
    else $error("bypass flag does not follow input");

endmodule // burst_sram_port

`default_nettype wire

// [dummy_end_marker_unused.sv]
`timescale 1ns/1ps
`default_nettype none
`default_nettype wire

// [sram_ctl_model.sv]
`timescale 1ns/1ps
`default_nettype none

module sram_ctl_model
  import sram_port_pkg::*;
#(
  parameter int UPPER_W = 4
) (
  input wire logic sys_clk,
  input wire logic [DQ_W-1:0] dq_out,
  input wire logic [DQ_W-1:0] dq_oe,
  output logic in_clk,
  output logic in_clk_n,
  output logic out_clk,
  output logic out_clk_n,
  output logic load_n,
  output logic read_not_write,
  output logic word_addr_bit0,
  output logic word_addr_bit1,
  output logic [UPPER_W-1:0] upper_addr,
  output logic [LANES-1:0] lane_write_enable_n,
  output logic [DQ_W-1:0] dq_in
);
  logic k_mode;
  logic [DQ_W-1:0] q [4];
  logic [DQ_W-1:0] oe [5];

  initial begin
    k_mode = 1'b0;
    {in_clk, in_clk_n, out_clk, out_clk_n} = 4'h5;
    {load_n, read_not_write, word_addr_bit0, word_addr_bit1} = 4'h8;
    upper_addr = '0;
    lane_write_enable_n = 4'hF;
    dq_in = '0;
  end

  // One half link period; the clock stands still when k repeats.
  task automatic step(input logic k, input logic ld, input logic rw,
      input logic [UPPER_W+1:0] a, input logic [DQ_W-1:0] d,
      input logic [LANES-1:0] be);
    in_clk <= k;
    in_clk_n <= !k;
    out_clk <= k_mode | k;
    out_clk_n <= k_mode | !k;
    load_n <= !ld;
    read_not_write <= rw;
    {upper_addr, word_addr_bit1, word_addr_bit0} <= ld ? a : ~a;
    dq_in <= d;
    lane_write_enable_n <= be;
    repeat (4) @(posedge sys_clk);
  endtask

  task automatic wr(input logic [UPPER_W+1:0] a, input logic [DQ_W-1:0] d [4],
      input logic [LANES-1:0] be [4]);
    for (int i = 0; i < 4; i++) begin
      step(!i[0], i == 0, 1'b0, a, d[i], be[i]);
    end
    step(1'b0, 1'b0, 1'b0, a, ~d[3], 4'hF);
  endtask

  task automatic rd(input logic [UPPER_W+1:0] a);
    step(1'b1, 1'b1, 1'b1, a, ~dq_in, 4'hF);
    for (int i = 0; i < 5; i++) begin
      step(i[0], 1'b0, 1'b1, a, ~dq_in, 4'hF);
      if (i < 4) begin
        q[i] = dq_out;
      end
      oe[i] = dq_oe;
    end
  endtask
endmodule // sram_ctl_model

`default_nettype wire

// [test_burst_sram_port.sv]
`timescale 1ns/1ps
`default_nettype none

module test_burst_sram_port;
  import sram_port_pkg::*;
  logic sys_clk, rst_n, hsel, hwrite, dll_disable_n;
  logic [31:0] haddr, hwdata, hrdata, r;
  logic [1:0] htrans;
  logic [2:0] hsize;
  wire logic hreadyout, hresp, dll_bypassed;
  wire logic in_clk, in_clk_n, out_clk, out_clk_n, load_n, rnw, wa0, wa1;
  wire logic [3:0] upper;
  wire logic [LANES-1:0] lwe_n;
  wire logic [DQ_W-1:0] dq_in, dq_out, dq_oe;
  logic [DQ_W-1:0] mem [4];
  logic [DQ_W-1:0] d [4];
  logic [LANES-1:0] be [4];
  int n_errors, comparisons, cyc;

  burst_sram_port DUT (.sys_clk(sys_clk), .rst_n(rst_n), .hsel(hsel),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
    .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout),
    .hresp(hresp), .hrdata(hrdata), .in_clk(in_clk), .in_clk_n(in_clk_n),
    .out_clk(out_clk), .out_clk_n(out_clk_n), .load_n(load_n),
    .read_not_write(rnw), .dll_disable_n(dll_disable_n),
    .word_addr_bit0(wa0), .word_addr_bit1(wa1), .upper_addr(upper),
    .lane_write_enable_n(lwe_n), .dq_in(dq_in), .dq_out(dq_out),
    .dq_oe(dq_oe), .dll_bypassed(dll_bypassed));

  sram_ctl_model u (.sys_clk(sys_clk), .dq_out(dq_out), .dq_oe(dq_oe),
    .in_clk(in_clk), .in_clk_n(in_clk_n), .out_clk(out_clk),
    .out_clk_n(out_clk_n), .load_n(load_n), .read_not_write(rnw),
    .word_addr_bit0(wa0), .word_addr_bit1(wa1), .upper_addr(upper),
    .lane_write_enable_n(lwe_n), .dq_in(dq_in));

  initial begin
    sys_clk = 1'b0;
    forever #12.5 sys_clk = ~sys_clk;
  end

  always @(posedge sys_clk) begin
    cyc++;
    if (cyc == 20000) begin
      n_errors++;
      test_done();
    end
  end

  task automatic check(input logic [DQ_W-1:0] seen, input logic [DQ_W-1:0] e);
    comparisons++;
    if (seen !== e) begin
      n_errors++;
      $display("ERROR %0t: seen %h expected %h", $time, seen, e);
    end
  endtask

  task automatic test_done;
    $display("errors %0d comparisons %0d", n_errors, comparisons);
    if (n_errors == 0 && comparisons > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask

  task automatic ahb(input logic wr, input logic [7:0] a,
      input logic [31:0] wd, output logic [31:0] rd);
    hsel <= 1'b1;
    htrans <= 2'b10;
    haddr <= {24'h0, a};
    hwrite <= wr;
    hsize <= 3'h2;
    do @(posedge sys_clk); while (hreadyout !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'b00;
    hwdata <= wd;
    do @(posedge sys_clk); while (hreadyout !== 1'b1);
    rd = hrdata;
  endtask

  task automatic rchk(input logic [7:0] a, input logic [31:0] e);
    logic [31:0] v;
    ahb(1'b0, a, 32'h0, v);
    check(36'(v), 36'(e));
  endtask

  // Lanes whose enable is low take the new data, the rest keep old data.
  function automatic logic [DQ_W-1:0] merge(input logic [DQ_W-1:0] o,
      input logic [DQ_W-1:0] n, input logic [LANES-1:0] en_n);
    merge = o;
    for (int l = 0; l < LANES; l++) begin
      if (!en_n[l]) begin
        merge[l*LANE_W +: LANE_W] = n[l*LANE_W +: LANE_W];
      end
    end
  endfunction

  task automatic burst_wr(input logic [1:0] s);
    for (int i = 0; i < 4; i++) begin
      mem[(s + i) % 4] = merge(mem[(s + i) % 4], d[i], be[i]);
    end
    u.wr({4'h5, s}, d, be);
  endtask

  task automatic rd_check(input logic [1:0] s, input logic [DQ_W-1:0] m);
    u.rd({4'h5, s});
    for (int i = 0; i < 4; i++) begin
      check(u.q[i] & m, mem[(s + i) % 4] & m);
      check(u.oe[i], m);
    end
    check(u.oe[4], '0);
  endtask

  initial begin
    {rst_n, hsel, hwrite, htrans, hsize, haddr, hwdata} = '0;
    dll_disable_n = 1'b1;
    repeat (20) @(posedge sys_clk);
    rst_n <= 1'b1;
    repeat (4) @(posedge sys_clk);
    check(hreadyout, 1'b1);
    check(hresp, 1'b0);
    check(dq_oe, '0);
    rchk(REG_CTRL, 32'h6);
    rchk(8'h10, 32'h0);
    ahb(1'b1, REG_LAST_ADDR, 32'hFFFFFFFF, r);
    rchk(REG_LAST_ADDR, 32'h0);
    dll_disable_n <= 1'b0;
    repeat (5) @(posedge sys_clk);
    check(dll_bypassed, 1'b1);
    rchk(REG_STATUS, 32'h2);
    dll_disable_n <= 1'b1;
    for (int i = 0; i < 4; i++) begin
      d[i] = 36'h123456780 + 36'(i * 36'h111111111);
      be[i] = 4'h0;
    end
    burst_wr(2'h2);
    be = '{4'hE, 4'h7, 4'h0, 4'hF};
    for (int i = 0; i < 4; i++) begin
      d[i] = ~d[i];
    end
    burst_wr(2'h1);
    rd_check(2'h3, '1);
    rchk(REG_LAST_ADDR, 32'h17);
    rchk(REG_XFER_COUNT, 32'h3);
    ahb(1'b1, REG_CTRL, {29'h0, 1'b1, WIDTH_X18}, r);
    rd_check(2'h1, 36'h3FFFF);
    ahb(1'b1, REG_CTRL, {29'h0, 1'b1, WIDTH_X8}, r);
    rd_check(2'h0, 36'hFF);
    ahb(1'b1, REG_CTRL, {29'h0, 1'b1, WIDTH_X36}, r);
    // Output clocks are tied high only from a fresh reset on, and must
    // stand high for a link period before the first read.
    rst_n <= 1'b0;
    u.k_mode = 1'b1;
    u.step(1'b0, 1'b0, 1'b0, '0, ~dq_in, 4'hF);
    rst_n <= 1'b1;
    repeat (12) @(posedge sys_clk);
    check(dll_bypassed, 1'b0);
    check(dq_oe, '0);
    be = '{default: 4'h0};
    burst_wr(2'h3);
    rd_check(2'h2, '1);
    rchk(REG_STATUS, 32'hC);
    rchk(REG_XFER_COUNT, 32'h2);
    test_done();
  end
endmodule // test_burst_sram_port

`default_nettype wire
